// File: host_port_pkg.sv
// Package for the 8-bit parallel host register port of the audio processor.
// Assumes one synchronous clock domain; shared by the port and its peak-meter bank.
package host_port_pkg;

    localparam int          CLK_PERIOD_NS   = 25;
    localparam logic [2:0]  PORT_DATA0      = 3'h0;
    localparam logic [2:0]  PORT_DATA4      = 3'h4;
    localparam logic [2:0]  PORT_ADDR_LOW   = 3'h5;
    localparam logic [2:0]  PORT_ADDR_HIGH  = 3'h6;
    localparam logic [2:0]  PORT_CTRL       = 3'h7;
    localparam logic [2:0]  PORT_STATUS     = 3'h7;

    localparam int          BYTE_W          = 8;
    localparam int          DATA_BYTES      = 5;
    localparam int          WORD_W          = 40;
    localparam int          SHORT_W         = 28;
    localparam int          TADDR_W         = 10;
    localparam int          METER_CH        = 8;
    localparam logic [9:0]  LAST_SLOT       = 10'h3ff;

    // Target-address high byte fields
    localparam int          AH_ADDR8        = 0;
    localparam int          AH_ADDR9        = 1;
    localparam int          AH_SEL_LO       = 2;
    localparam int          AH_SEL_HI       = 3;
    localparam int          AH_READ         = 4;
    localparam int          AH_IMMED        = 5;

    localparam int          CW_SELECT_BIT   = 7;

    // Reset values of the two control words
    localparam logic [7:0]  CW0_RESET       = 8'h00;
    localparam logic [7:0]  CW1_RESET       = 8'h42;

    typedef enum logic [1:0] {
        MEM_INSTR = 2'h0,
        MEM_RSVD  = 2'h1,
        MEM_SAMPLE= 2'h2,
        MEM_DIRECT= 2'h3
    } mem_sel_t;

    typedef struct packed {
        logic       spare;
        logic [3:0] out_enable;
        logic       in_enable;
        logic [1:0] conv_format;
    } cw0_t;

    typedef struct packed {
        logic       spare;
        logic       prog_write_block;
        logic       readout_ram;
        logic       meter_output;
        logic       word_clk_invert;
        logic       mac_round;
        logic       offset_cnt_off;
        logic       reserved0;
    } cw1_t;

    typedef struct packed {
        logic                 valid;
        logic                 is_read;
        mem_sel_t             mem;
        logic [TADDR_W-1:0]   addr;
        logic [WORD_W-1:0]    wdata;
    } mem_req_t;

endpackage : host_port_pkg

// File: host_port_regs.sv
// Register side of the 8-bit parallel host port: staging, access trigger,
// control words, status byte and peak readout. Assumes the bus strobes are
// already synchronous one-cycle pulses and the memory side answers with done.
//
// Contract
// R01: RAM access takes address high bits 0 and 1 as target bits 8, 9.
// R02: High byte bits 3:2 select instruction, reserved, sample, or direct memory.
// R03: High byte bit 4 chooses write (zero) or read (one).
// R04: High byte bit 5 chooses deferred-to-slot-1023 or immediate access.
// R05: Host should prefer deferred access and keep slot 1023 memory-free.
// R06: Host applies the same collision care to general register writes.
// R07: Host always writes ones into high byte bits 6 and 7.
// R08: Writing port 6 triggers the access using staged bytes 0 to 4.
// R09: Port 7 writes go to control word 0 or 1 by bit 7.
// R10: Control word 0 bits 1:0 set converter format, default zero.
// R11: Control word 0 bit 2 enables serial inputs; muted after reset.
// R12: Control word 0 bits 3..6 enable outputs 0..3; muted after reset.
// R13: Control word 1 bit 1 disables offset counter; default disabled.
// R14: Control word 1 bit 2 rounds MAC results; default truncation.
// R15: Control word 1 bit 3 inverts internal word clock; default normal.
// R16: Control word 1 bit 6 blocks program memory writes; default blocked.
// R17: Status bit 0 reads one while a host access is pending.
// R18: Status bits 1..5 show mutes; bits 6, 7 flag MAC and output overflow.
// R19: MAC results saturate on overflow except integer instructions.
// R20: RAM and status reads need control word 1 bit 5; writes always proceed.
// R21: Data is LSB aligned; short words zero the top 12 bits.
// R22: With bit 5 clear, bit 4 picks input or output meters; A2-A0 pick channel.
// R23: Reading a meter clears it so peak accumulation restarts.
// R24: Ports 0..4 hold data LSB first, 5 address low, 7 returns status.
// R25: Pending sets on the trigger write and clears when transfer completes.
`timescale 1ns/1ps
module host_port_regs
    import host_port_pkg::*;
(
    input  wire logic                       core_clk,             // System clock
    input  wire logic                       sys_rst,              // Sync reset, high
    input  wire logic                       port_select_line_2,   // Port address bit 2
    input  wire logic                       port_select_line_1,   // Port address bit 1
    input  wire logic                       port_select_line_0,   // Port address bit 0
    input  wire logic                       host_wr,              // Write pulse
    input  wire logic                       host_rd,              // Read pulse
    input  wire logic [BYTE_W-1:0]          host_wdata,           // Write byte
    output logic      [BYTE_W-1:0]          host_rdata,           // Read byte
    input  wire logic [TADDR_W-1:0]         slot_index,           // Executing slot
    output mem_req_t                        mem_req,              // Access to memory side
    input  wire logic                       mem_done,             // Access finished
    input  wire logic [WORD_W-1:0]          mem_rdata,            // Read word
    input  wire logic                       sample_word_clock,    // External word clock
    output logic                            int_word_clock,       // Internal word clock
    output logic [1:0]                      conv_format,          // Converter format
    output logic                            in_enable,            // Serial inputs on
    output logic                            serial_output_line_0, // Output 0 enabled
    output logic                            serial_output_line_1, // Output 1 enabled
    output logic                            serial_output_line_2, // Output 2 enabled
    output logic                            serial_output_line_3, // Output 3 enabled
    output logic                            offset_cnt_en,        // Offset counter on
    output logic                            mac_round,            // Round MAC results
    output logic                            prog_write_en,        // Program may write
    input  wire logic [WORD_W-1:0]          mac_acc,              // Raw MAC result
    input  wire logic                       mac_ovf,              // MAC overflowed
    input  wire logic                       mac_integer,          // Integer instruction
    output logic      [WORD_W-1:0]          mac_result,           // Saturated result
    input  wire logic                       out_clip,             // Output clipped
    input  wire logic [METER_CH*BYTE_W-1:0] in_level,             // Input meter levels
    input  wire logic [METER_CH*BYTE_W-1:0] out_level,            // Output meter levels
    input  wire logic                       level_stb             // Meter sample strobe
);

    logic [BYTE_W-1:0]  stage_ff [DATA_BYTES];
    logic [BYTE_W-1:0]  addr_lo_ff;
    cw0_t               cw0_ff;
    cw1_t               cw1_ff;
    mem_req_t           req_ff;
    logic               pending_ff;
    logic               mac_ovf_ff;
    logic               out_clip_ff;
    logic [BYTE_W-1:0]  rdata_ff;
    logic [2:0]         port;
    logic               wr_data;
    logic               trig;
    logic [WORD_W-1:0]  nxt_wdata;
    logic [BYTE_W-1:0]  status;
    logic [BYTE_W-1:0]  meter_val;
    logic               meter_rd;
    logic [WORD_W-1:0]  rd_word;

    assign port    = {port_select_line_2, port_select_line_1, port_select_line_0};
    assign wr_data = host_wr && (port <= PORT_DATA4);
    assign trig    = host_wr && (port == PORT_ADDR_HIGH);

    for (genvar b = 0; b < DATA_BYTES; b++) begin : g_stage
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                stage_ff[b] <= 8'h00;
            end else if (wr_data && port == 3'(b)) begin // see R24
                stage_ff[b] <= host_wdata;
            end else if (req_ff.valid && req_ff.is_read && mem_done) begin
                stage_ff[b] <= rd_word[b*BYTE_W +: BYTE_W];
            end
        end
        assign nxt_wdata[b*BYTE_W +: BYTE_W] = (wr_data && port == 3'(b)) ? host_wdata
                                                                          : stage_ff[b];
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            addr_lo_ff <= 8'h00;
        end else if (host_wr && port == PORT_ADDR_LOW) begin // see R24
            addr_lo_ff <= host_wdata;
        end
    end

    // Control words share one port; bit 7 of the byte picks the target
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cw0_ff <= CW0_RESET;  // see R10 see R11 see R12
            cw1_ff <= CW1_RESET;  // see R13 see R14 see R15 see R16
        end else if (host_wr && port == PORT_CTRL) begin
            if (host_wdata[CW_SELECT_BIT]) begin // see R09
                cw1_ff <= host_wdata;
            end else begin
                cw0_ff <= host_wdata;
            end
        end
    end

    // Request is launched now or held until the last slot comes round
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            req_ff <= '0;
        end else if (trig) begin // see R08
            req_ff.valid   <= host_wdata[AH_IMMED]; // see R04
            req_ff.is_read <= host_wdata[AH_READ];  // see R03
            req_ff.mem     <= mem_sel_t'(host_wdata[AH_SEL_HI:AH_SEL_LO]); // see R02
            req_ff.addr    <= {host_wdata[AH_ADDR9], host_wdata[AH_ADDR8], addr_lo_ff}; // see R01
            req_ff.wdata   <= nxt_wdata;
        end else if (req_ff.valid && mem_done) begin
            req_ff.valid <= 1'b0;
        end else if (pending_ff && !req_ff.valid && slot_index == LAST_SLOT) begin
            req_ff.valid <= 1'b1; // see R04
        end
    end

    // A new trigger wins over a completion in the same cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pending_ff <= 1'b0;
        end else if (trig) begin // see R25
            pending_ff <= 1'b1;
        end else if (req_ff.valid && mem_done) begin // see R17
            pending_ff <= 1'b0;
        end
    end

    assign mem_req = req_ff;

    // Short words keep only the low bits so the top twelve read as zero
    assign rd_word = (req_ff.mem == MEM_INSTR) ? mem_rdata
                   : {{(WORD_W-SHORT_W){1'b0}}, mem_rdata[SHORT_W-1:0]}; // see R21

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mac_ovf_ff <= 1'b0;
        end else if (mac_ovf && !mac_integer) begin
            mac_ovf_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            out_clip_ff <= 1'b0;
        end else if (out_clip) begin
            out_clip_ff <= 1'b1;
        end
    end

    // Saturate toward the sign of the raw sum; integer opcodes wrap
    always_comb begin
        mac_result = mac_acc;
        if (mac_ovf && !mac_integer) begin // see R19
            mac_result = mac_acc[WORD_W-1] ? {1'b1, {(WORD_W-1){1'b0}}}
                                           : {1'b0, {(WORD_W-1){1'b1}}};
        end
    end

    assign status = {out_clip_ff, mac_ovf_ff, ~cw0_ff.out_enable,
                     ~cw0_ff.in_enable, pending_ff}; // see R17 see R18

    assign meter_rd = host_rd && !cw1_ff.readout_ram;

    peak_meter_bank u_meters (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .in_level  (in_level),
        .out_level (out_level),
        .level_stb (level_stb),
        .rd_stb    (meter_rd),
        .rd_output (cw1_ff.meter_output),
        .rd_ch     (port),
        .rd_value  (meter_val)
    );

    // Reads only expose RAM and status while the readout bit is set
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_ff <= 8'h00;
        end else if (host_rd) begin
            if (!cw1_ff.readout_ram) begin
                rdata_ff <= meter_val; // see R22
            end else if (port == PORT_STATUS) begin
                rdata_ff <= status; // see R20
            end else if (port <= PORT_DATA4) begin
                rdata_ff <= stage_ff[port]; // see R20 see R24
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end

    assign host_rdata           = rdata_ff;
    assign int_word_clock       = sample_word_clock ^ cw1_ff.word_clk_invert; // see R15
    assign conv_format          = cw0_ff.conv_format;
    assign in_enable            = cw0_ff.in_enable;
    assign serial_output_line_0 = cw0_ff.out_enable[0];
    assign serial_output_line_1 = cw0_ff.out_enable[1];
    assign serial_output_line_2 = cw0_ff.out_enable[2];
    assign serial_output_line_3 = cw0_ff.out_enable[3];
    assign offset_cnt_en        = !cw1_ff.offset_cnt_off;
    assign mac_round            = cw1_ff.mac_round;
    assign prog_write_en        = !cw1_ff.prog_write_block;

    property p_trig_pending;
        @(posedge core_clk) disable iff (sys_rst) trig |=> pending_ff;
    endproperty
    a_trig_pending: assert property (p_trig_pending) else $error("pending not set"); // see R25

    property p_done_clears;
        @(posedge core_clk) disable iff (sys_rst)
            (req_ff.valid && mem_done && !trig) |=> !pending_ff && !req_ff.valid;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("done kept pending"); // see R17

    sequence s_deferred_trig;
        trig && !host_wdata[AH_IMMED];
    endsequence
    property p_defer;
        @(posedge core_clk) disable iff (sys_rst) s_deferred_trig |=> !mem_req.valid;
    endproperty
    a_defer: assert property (p_defer) else $error("deferred access fired early"); // see R04

    property p_immed;
        @(posedge core_clk) disable iff (sys_rst)
            trig && host_wdata[AH_IMMED] |=> mem_req.valid;
    endproperty
    a_immed: assert property (p_immed) else $error("immediate access not issued"); // see R04

    property p_addr;
        @(posedge core_clk) disable iff (sys_rst)
            trig |=> mem_req.addr[TADDR_W-1:BYTE_W] == $past(host_wdata[AH_ADDR9:AH_ADDR8]);
    endproperty
    a_addr: assert property (p_addr) else $error("target high bits wrong"); // see R01

    property p_dir;
        @(posedge core_clk) disable iff (sys_rst)
            trig |=> mem_req.is_read == $past(host_wdata[AH_READ])
                     && mem_req.mem == mem_sel_t'($past(host_wdata[AH_SEL_HI:AH_SEL_LO]));
    endproperty
    a_dir: assert property (p_dir) else $error("direction or memory wrong"); // see R02 see R03

    property p_cw_sel;
        @(posedge core_clk) disable iff (sys_rst)
            host_wr && port == PORT_CTRL && !host_wdata[CW_SELECT_BIT] |=> $stable(cw1_ff);
    endproperty
    a_cw_sel: assert property (p_cw_sel) else $error("word 1 changed on word 0 write"); // see R09

    // Checked through the read path against the enable pins the port drives
    property p_status_mute;
        @(posedge core_clk) disable iff (sys_rst)
            host_rd && cw1_ff.readout_ram && port == PORT_STATUS
            |=> host_rdata[5:0] == {~$past({serial_output_line_3, serial_output_line_2,
                                            serial_output_line_1, serial_output_line_0,
                                            in_enable}), $past(pending_ff)};
    endproperty
    a_status_mute: assert property (p_status_mute) else $error("mute status wrong"); // see R18 see R20

    property p_meter_read;
        @(posedge core_clk) disable iff (sys_rst)
            host_rd && !cw1_ff.readout_ram |=> host_rdata == $past(meter_val);
    endproperty
    a_meter_read: assert property (p_meter_read) else $error("meter readout wrong"); // see R22

endmodule : host_port_regs

// File: mem_side_model.sv
// Memory-side responder for the host port: answers each request with a done pulse.
// Assumes one outstanding request and a latency chosen by the bench.
`timescale 1ns/1ps
module mem_side_model
    import host_port_pkg::*;
#(
    parameter logic [WORD_W-1:0] RD_WORD = 40'hfedcba9876
)(
    input  wire logic              core_clk,  // System clock
    input  wire logic              sys_rst,   // Sync reset, high
    input  wire mem_req_t          mem_req,   // Request from the port
    input  wire logic [3:0]        lat,       // Cycles before done
    output logic                   mem_done,  // One-cycle finish pulse
    output logic [WORD_W-1:0]      mem_rdata  // Read word, valid with done
);
    logic [3:0] cnt_ff;

    always_ff @(posedge core_clk) begin
        if (sys_rst || !mem_req.valid || mem_done) begin
            cnt_ff   <= 4'h0;
            mem_done <= 1'b0;
        end else if (cnt_ff == lat) begin
            mem_done <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end

    // Outside the done cycle the bus shows garbage, never a stale good word
    assign mem_rdata = mem_done ? RD_WORD : ~RD_WORD;
endmodule : mem_side_model

// File: peak_meter_bank.sv
// Per-channel peak-hold registers for eight input and eight output meters.
// Assumes meter levels arrive already scaled; a read clears the chosen meter.
`timescale 1ns/1ps
module peak_meter_bank
    import host_port_pkg::*;
(
    input  wire logic                       core_clk,     // System clock
    input  wire logic                       sys_rst,      // Sync reset, high
    input  wire logic [METER_CH*BYTE_W-1:0] in_level,     // Input meter levels
    input  wire logic [METER_CH*BYTE_W-1:0] out_level,    // Output meter levels
    input  wire logic                       level_stb,    // New levels this cycle
    input  wire logic                       rd_stb,       // Meter read strobe
    input  wire logic                       rd_output,    // Pick output bank
    input  wire logic [2:0]                 rd_ch,        // Channel select
    output logic      [BYTE_W-1:0]          rd_value      // Held peak
);

    logic [BYTE_W-1:0] in_pk_ff  [METER_CH];
    logic [BYTE_W-1:0] out_pk_ff [METER_CH];

    for (genvar c = 0; c < METER_CH; c++) begin : g_ch
        logic [BYTE_W-1:0] il;
        logic [BYTE_W-1:0] ol;
        logic              clr_in;
        logic              clr_out;
        assign il      = in_level[c*BYTE_W +: BYTE_W];
        assign ol      = out_level[c*BYTE_W +: BYTE_W];
        assign clr_in  = rd_stb && !rd_output && (rd_ch == 3'(c));
        assign clr_out = rd_stb && rd_output && (rd_ch == 3'(c));
        // A sample landing with the read restarts the hold from that sample
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                in_pk_ff[c] <= 8'h00;
            end else if (clr_in) begin // see R23
                in_pk_ff[c] <= level_stb ? il : 8'h00;
            end else if (level_stb && il > in_pk_ff[c]) begin
                in_pk_ff[c] <= il;
            end
        end
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                out_pk_ff[c] <= 8'h00;
            end else if (clr_out) begin // see R23
                out_pk_ff[c] <= level_stb ? ol : 8'h00;
            end else if (level_stb && ol > out_pk_ff[c]) begin
                out_pk_ff[c] <= ol;
            end
        end
    end

    assign rd_value = rd_output ? out_pk_ff[rd_ch] : in_pk_ff[rd_ch]; // see R22

endmodule : peak_meter_bank

// File: tb_host_port_regs.sv
// Self-checking bench for the host register port with a memory-side responder.
// Assumes read data appears one cycle after the read pulse.
`timescale 1ns/1ps
module tb_host_port_regs;
    import host_port_pkg::*;
    logic        core_clk = 0, sys_rst = 1, host_wr = 0, host_rd = 0, level_stb = 0;
    logic        mac_ovf = 0, out_clip = 0, mem_done, iwc, in_en, off_en, rnd, pw;
    logic        mac_int = 1, swc = 1;
    logic [2:0]  port = 0;
    logic [7:0]  host_wdata = 0, host_rdata;
    logic [9:0]  slot_index = 0;
    logic [3:0]  lat = 1, outs;
    logic [1:0]  fmt;
    logic [39:0] mem_rdata, mac_result, mac_acc = 40'h123456789a;
    logic [63:0] in_level = 0, out_level = 0;
    mem_req_t    mem_req;
    int          failures = 0, n_tests = 0;
    logic [7:0]  row_in  [7] = '{8'h00, 8'h7d, 8'h2a, 8'h03, 8'h8c, 8'hc2, 8'ha2};
    logic [10:0] row_out [7] = '{11'h001, 11'h3f1, 11'h4a1, 11'h601, 11'h60e, 11'h601, 11'h603};

    always #(CLK_PERIOD_NS / 2.0) core_clk = ~core_clk;

    host_port_regs u_host_port_regs (
        .core_clk(core_clk), .sys_rst(sys_rst), .port_select_line_2(port[2]),
        .port_select_line_1(port[1]), .port_select_line_0(port[0]), .host_wr(host_wr),
        .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .slot_index(slot_index), .mem_req(mem_req), .mem_done(mem_done),
        .mem_rdata(mem_rdata), .sample_word_clock(swc), .int_word_clock(iwc),
        .conv_format(fmt), .in_enable(in_en), .serial_output_line_0(outs[3]),
        .serial_output_line_1(outs[2]), .serial_output_line_2(outs[1]),
        .serial_output_line_3(outs[0]), .offset_cnt_en(off_en), .mac_round(rnd),
        .prog_write_en(pw), .mac_acc(mac_acc), .mac_ovf(mac_ovf), .mac_integer(mac_int),
        .mac_result(mac_result), .out_clip(out_clip), .in_level(in_level),
        .out_level(out_level), .level_stb(level_stb));

    mem_side_model u_mem_side_model (
        .core_clk(core_clk), .sys_rst(sys_rst), .mem_req(mem_req), .lat(lat),
        .mem_done(mem_done), .mem_rdata(mem_rdata));

    task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [2:0] p, input logic [7:0] d);
        @(posedge core_clk);
        #1 port = p;
        host_wdata = d;
        host_wr = 1;
        @(posedge core_clk);
        #1 host_wr = 0;
    endtask : wr

    task automatic rd(input logic [2:0] p, input logic [7:0] exp, input string nm);
        @(posedge core_clk);
        #1 port = p;
        host_rd = 1;
        @(posedge core_clk);
        #1 host_rd = 0;
        chk(nm, 40'(exp), 40'(host_rdata));
    endtask : rd

    // Bounded wait so a request that never moves cannot hang the run
    task automatic wait_valid(input logic lvl);
        for (int i = 0; i < 20 && mem_req.valid !== lvl; i++) begin
            @(posedge core_clk);
            #1;
        end
        chk("mem_req.valid", 40'(lvl), 40'(mem_req.valid));
    endtask : wait_valid

    task automatic final_report();
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    initial begin
        #(CLK_PERIOD_NS * 2000);
        failures++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        #1 sys_rst = 0;
        chk("reset valid", 40'h0, 40'(mem_req.valid));
        chk("reset controls", 40'h0, 40'({fmt, in_en, outs, off_en, rnd, pw}));
        in_level[31:24] = 8'h5a;
        out_level[31:24] = 8'h77;
        level_stb = 1;
        @(posedge core_clk);
        #1 level_stb = 0;
        rd(3'h3, 8'h5a, "input peak");
        rd(3'h3, 8'h00, "input peak cleared");
        wr(PORT_CTRL, 8'hd2);
        rd(3'h3, 8'h77, "output peak");
        for (int k = 0; k < 7; k++) begin
            wr(PORT_CTRL, row_in[k]);
            chk("controls", 40'(row_out[k]), 40'({fmt, in_en, outs, off_en, rnd, pw, iwc}));
        end
        swc = 0;
        #1 chk("word clock low", 40'h0, 40'(iwc));
        rd(PORT_STATUS, 8'h3e, "status idle");
        mac_ovf = 1;
        out_clip = 1;
        #1 chk("integer mac", mac_acc, mac_result);
        mac_int = 0;
        #1 chk("saturated mac", 40'h7fffffffff, mac_result);
        @(posedge core_clk);
        #1 mac_ovf = 0;
        out_clip = 0;
        rd(PORT_STATUS, 8'hfe, "status overflow");
        // Immediate instruction write, slow memory side
        lat = 4'h6;
        for (int b = 0; b < 5; b++) wr(3'(b), 8'(8'h11 * (b + 1)));
        wr(PORT_ADDR_LOW, 8'hab);
        wr(PORT_ADDR_HIGH, 8'he2);
        chk("write req", 40'({2'b10, MEM_INSTR, 10'h2ab}), 40'({mem_req.valid, mem_req.is_read, mem_req.mem, mem_req.addr}));
        chk("write word", 40'h5544332211, mem_req.wdata);
        rd(PORT_STATUS, 8'hff, "status pending");
        wait_valid(1'b0);
        rd(PORT_STATUS, 8'hfe, "status done");
        // Deferred sample read waits for the last slot
        lat = 4'h1;
        wr(PORT_ADDR_HIGH, 8'hd9);
        repeat (4) @(posedge core_clk);
        #1 chk("deferred hold", 40'h0, 40'(mem_req.valid));
        slot_index = LAST_SLOT;
        wait_valid(1'b1);
        slot_index = 10'h000;
        chk("read req", 40'({1'b1, MEM_SAMPLE, 10'h1ab}), 40'({mem_req.is_read, mem_req.mem, mem_req.addr}));
        wait_valid(1'b0);
        for (int b = 0; b < 5; b++) rd(3'(b), 8'(40'h000cba9876 >> (8 * b)), "read byte");
        // Reset in mid-run drops a pending request and the sticky flags
        wr(PORT_ADDR_HIGH, 8'hcc);
        sys_rst = 1;
        repeat (2) @(posedge core_clk);
        #1 sys_rst = 0;
        chk("mid reset valid", 40'h0, 40'(mem_req.valid));
        chk("mid reset controls", 40'h0, 40'({fmt, in_en, outs, off_en, rnd, pw}));
        wr(PORT_CTRL, 8'ha2);
        rd(PORT_STATUS, 8'h3e, "status after reset");
        final_report();
    end
endmodule : tb_host_port_regs
